// ---- logic/irqr_defs.vh ----
/*
 * Constants for the interrupt pin routing and output rate block:
 * register offsets, field positions, reset values, rate and divider
 * tables. Assumes it is included by its bare name from logic/ files.
 */
`ifndef IRQR_DEFS_VH
`define IRQR_DEFS_VH

// register offsets
`define IRQR_ADDR_RATE 8'h08
`define IRQR_ADDR_COMB 8'h2D
`define IRQR_ADDR_DEC 8'h30
`define IRQR_ADDR_SWAP 8'h31
`define IRQR_ADDR_PIN 8'h33

// reset values
`define IRQR_RST_RATE 8'h08
`define IRQR_RST_PIN 8'h00
`define IRQR_RST_DEC 4'h0
`define IRQR_RST_COMB 1'b0
`define IRQR_RST_SWAP 1'b0

// field positions
`define IRQR_BIT_COMB 3
`define IRQR_BIT_SWAP 4
`define IRQR_BIT_A_AH 2
`define IRQR_BIT_A_PP 3
`define IRQR_BIT_B_AH 6
`define IRQR_BIT_B_PP 7
`define IRQR_DEC_MSB 3
`define IRQR_RATE_VALID 3
`define IRQR_RATE_IDX_MSB 2
`define IRQR_PIN_MASK 8'hCC

// internal rates in Hz, index = sample rate code minus 0x08
`define IRQR_RATE0_HZ 50
`define IRQR_RATE1_HZ 100
`define IRQR_RATE2_HZ 125
`define IRQR_RATE3_HZ 200
`define IRQR_RATE4_HZ 250
`define IRQR_RATE5_HZ 500
`define IRQR_RATE6_HZ 1000
`define IRQR_RATE7_HZ 2000

// decimation divisors by field code
`define IRQR_DIV_0 10'h001
`define IRQR_DIV_1 10'h002
`define IRQR_DIV_2 10'h004
`define IRQR_DIV_3 10'h005
`define IRQR_DIV_4 10'h008
`define IRQR_DIV_5 10'h00A
`define IRQR_DIV_6 10'h010
`define IRQR_DIV_7 10'h014
`define IRQR_DIV_8 10'h028
`define IRQR_DIV_9 10'h043
`define IRQR_DIV_10 10'h050
`define IRQR_DIV_11 10'h064
`define IRQR_DIV_12 10'h0C8
`define IRQR_DIV_13 10'h0FA
`define IRQR_DIV_14 10'h1F4
`define IRQR_DIV_15 10'h3E8

`endif

// ---- logic/irqr_pin_drv.v ----
/*
 * Output stage of one interrupt pin: polarity and drive style.
 * Assumes the board or bench resolves the wire from out and oe and
 * supplies a pull-up in open-drain use.
 */
module irqr_pin_drv (
	input wire clk,
	input wire sys_rst,
	input wire req,
	input wire active_high,
	input wire push_pull,
	output reg pin_out_q,
	output reg pin_oe_q
);
	always @(posedge clk) begin
		if (sys_rst) begin
			pin_out_q <= 1'b0;
			pin_oe_q <= 1'b0;
		end else if (push_pull) begin
			pin_oe_q <= 1'b1;
			pin_out_q <= req ? active_high : ~active_high;
		end else begin
			// released when idle, so the pull-up sets the idle level
			pin_oe_q <= req;
			pin_out_q <= active_high;
		end
	end
endmodule

// ---- logic/irqr_pin_rate.v ----
/*
 * Output rate generation and routing of the two interrupt requests
 * onto two pins, with swap, combine, polarity and drive control.
 * Assumes a register port from the serial interface logic, inputs
 * synchronous to clk, and a filtered sample stream from the filter.
 */

// Operation
// - two interrupt pins, each with own polarity and own drive style.
// - by default motion+sample request drives pin a, fifo request pin b.
// - pin control bit 2 sets pin a active low at 0, high at 1.
// - pin control bit 3 sets pin a open-drain at 0, push-pull at 1.
// - pin control bit 6 sets pin b active low at 0, high at 1.
// - pin control bit 7 sets pin b open-drain at 0, push-pull at 1.
// - swap bit 4 of 0x31 exchanges the requests between the two pins.
// - swap moves requests only; polarity and drive stay with each pin.
// - combine bit 3 of 0x2D merges all onto request one, silences two.
// - combine with swap puts the merged request on pin b.
// - sample output registers update once per output rate period.
// - with acquisition enabled, each sample update raises a request.
// - rate codes 0x08 to 0x0F pick 50 to 2000 Hz internal rates.
// - decimation code 0 disables; codes 1 to 7 divide by 2..20.
// - decimation codes 8 to 15 divide by 40 up to 1000.
// - fifo, motion, outputs and interrupts run at the decimated rate.
// - the low pass filter always runs at the internal rate.
`include "irqr_defs.vh"

module irqr_pin_rate #(
	parameter CLK_HZ = 10000000,
	parameter CW = 24,
	parameter SW = 16
) (
	input wire clk,
	input wire sys_rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_we,
	input wire reg_re,
	output reg [7:0] reg_rdata_q,
	input wire acq_irq_en,
	input wire acq_irq_clear,
	input wire motion_sample_request,
	input wire fifo_request,
	input wire [SW-1:0] x_sample_in,
	input wire [SW-1:0] y_sample_in,
	input wire [SW-1:0] z_sample_in,
	output reg [SW-1:0] x_sample_out,
	output reg [SW-1:0] y_sample_out,
	output reg [SW-1:0] z_sample_out,
	output wire internal_rate_tick,
	output wire output_rate_tick,
	output reg acquisition_irq,
	output wire irq_pin_a_out,
	output wire irq_pin_a_oe,
	output wire irq_pin_b_out,
	output wire irq_pin_b_oe
);
	// clock cycles per internal sample for each rate, cut to the
	// counter width on purpose: the slowest period must fit in CW bits
	localparam integer FULL0 = CLK_HZ / `IRQR_RATE0_HZ;
	localparam integer FULL1 = CLK_HZ / `IRQR_RATE1_HZ;
	localparam integer FULL2 = CLK_HZ / `IRQR_RATE2_HZ;
	localparam integer FULL3 = CLK_HZ / `IRQR_RATE3_HZ;
	localparam integer FULL4 = CLK_HZ / `IRQR_RATE4_HZ;
	localparam integer FULL5 = CLK_HZ / `IRQR_RATE5_HZ;
	localparam integer FULL6 = CLK_HZ / `IRQR_RATE6_HZ;
	localparam integer FULL7 = CLK_HZ / `IRQR_RATE7_HZ;
	localparam [CW-1:0] PER0 = FULL0[CW-1:0];
	localparam [CW-1:0] PER1 = FULL1[CW-1:0];
	localparam [CW-1:0] PER2 = FULL2[CW-1:0];
	localparam [CW-1:0] PER3 = FULL3[CW-1:0];
	localparam [CW-1:0] PER4 = FULL4[CW-1:0];
	localparam [CW-1:0] PER5 = FULL5[CW-1:0];
	localparam [CW-1:0] PER6 = FULL6[CW-1:0];
	localparam [CW-1:0] PER7 = FULL7[CW-1:0];

	reg [7:0] rate_code_q;
	reg [7:0] irq_pin_drive_polarity_q;
	reg request_combine_q;
	reg request_swap_q;
	reg [3:0] decimation_divider_sel_q;
	reg acq_flag_q;

	reg [CW-1:0] idr_period;
	reg [9:0] dec_div;
	reg [2:0] rate_idx;
	reg req_one;
	reg req_two;
	reg req_a;
	reg req_b;
	reg [7:0] rdata_d;

	// register writes
	always @(posedge clk) begin
		if (sys_rst) begin
			rate_code_q <= `IRQR_RST_RATE;
			irq_pin_drive_polarity_q <= `IRQR_RST_PIN;
			request_combine_q <= `IRQR_RST_COMB;
			request_swap_q <= `IRQR_RST_SWAP;
			decimation_divider_sel_q <= `IRQR_RST_DEC;
		end else if (reg_we) begin
			case (reg_addr)
			`IRQR_ADDR_RATE: begin
				rate_code_q <= reg_wdata;
			end
			`IRQR_ADDR_PIN: begin
				// reserved bits are not stored
				irq_pin_drive_polarity_q <= reg_wdata & `IRQR_PIN_MASK;
			end
			`IRQR_ADDR_COMB: begin
				request_combine_q <= reg_wdata[`IRQR_BIT_COMB];
			end
			`IRQR_ADDR_SWAP: begin
				request_swap_q <= reg_wdata[`IRQR_BIT_SWAP];
			end
			`IRQR_ADDR_DEC: begin
				decimation_divider_sel_q <= reg_wdata[`IRQR_DEC_MSB:0];
			end
			default: begin
			end
			endcase
		end
	end

	// register reads; bits this block does not own read as zero
	always @* begin
		rdata_d = 8'h00;
		case (reg_addr)
		`IRQR_ADDR_RATE: begin
			rdata_d = rate_code_q;
		end
		`IRQR_ADDR_PIN: begin
			rdata_d = irq_pin_drive_polarity_q;
		end
		`IRQR_ADDR_COMB: begin
			rdata_d[`IRQR_BIT_COMB] = request_combine_q;
		end
		`IRQR_ADDR_SWAP: begin
			rdata_d[`IRQR_BIT_SWAP] = request_swap_q;
		end
		`IRQR_ADDR_DEC: begin
			rdata_d[`IRQR_DEC_MSB:0] = decimation_divider_sel_q;
		end
		default: rdata_d = 8'h00;
		endcase
	end

	// read data holds until the next read strobe
	always @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_re) begin
			reg_rdata_q <= rdata_d;
		end
	end

	// internal rate select; codes below 0x08 fall back to the slowest
	always @* begin
		rate_idx = 3'h0;
		if (rate_code_q[`IRQR_RATE_VALID]) begin
			rate_idx = rate_code_q[`IRQR_RATE_IDX_MSB:0];
		end
	end

	// one period per rate index; the table covers every index
	always @* begin
		case (rate_idx)
		3'h0: idr_period = PER0;
		3'h1: idr_period = PER1;
		3'h2: idr_period = PER2;
		3'h3: idr_period = PER3;
		3'h4: idr_period = PER4;
		3'h5: idr_period = PER5;
		3'h6: idr_period = PER6;
		3'h7: idr_period = PER7;
		default: idr_period = PER0;
		endcase
	end

	// decimation divisor; divide by one means output rate = internal
	always @* begin
		case (decimation_divider_sel_q)
		4'h0: dec_div = `IRQR_DIV_0;
		4'h1: dec_div = `IRQR_DIV_1;
		4'h2: dec_div = `IRQR_DIV_2;
		4'h3: dec_div = `IRQR_DIV_3;
		4'h4: dec_div = `IRQR_DIV_4;
		4'h5: dec_div = `IRQR_DIV_5;
		4'h6: dec_div = `IRQR_DIV_6;
		4'h7: dec_div = `IRQR_DIV_7;
		4'h8: dec_div = `IRQR_DIV_8;
		4'h9: dec_div = `IRQR_DIV_9;
		4'hA: dec_div = `IRQR_DIV_10;
		4'hB: dec_div = `IRQR_DIV_11;
		4'hC: dec_div = `IRQR_DIV_12;
		4'hD: dec_div = `IRQR_DIV_13;
		4'hE: dec_div = `IRQR_DIV_14;
		4'hF: dec_div = `IRQR_DIV_15;
		default: dec_div = `IRQR_DIV_0;
		endcase
	end

	// filter tick stays at the internal rate regardless of decimation
	irqr_tick_div #(
		.W(CW)
	) u_idr (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_tick(1'b1),
		.period(idr_period),
		.out_tick_q(internal_rate_tick)
	);

	// counts internal ticks, so every output tick comes one cycle after a filter tick
	irqr_tick_div #(
		.W(10)
	) u_odr (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_tick(internal_rate_tick),
		.period(dec_div),
		.out_tick_q(output_rate_tick)
	);

	// sample registers load on the output rate tick only
	always @(posedge clk) begin
		if (sys_rst) begin
			x_sample_out <= {SW{1'b0}};
			y_sample_out <= {SW{1'b0}};
			z_sample_out <= {SW{1'b0}};
		end else if (output_rate_tick) begin
			x_sample_out <= x_sample_in;
			y_sample_out <= y_sample_in;
			z_sample_out <= z_sample_in;
		end
	end

	// acquisition flag: a new sample in the clearing cycle still sets it
	always @(posedge clk) begin
		if (sys_rst) begin
			acq_flag_q <= 1'b0;
		end else if (output_rate_tick & acq_irq_en) begin
			acq_flag_q <= 1'b1;
		end else if (acq_irq_clear) begin
			acq_flag_q <= 1'b0;
		end
	end

	// the visible copy lags the flag by one edge, like the pins do
	always @(posedge clk) begin
		if (sys_rst) begin
			acquisition_irq <= 1'b0;
		end else begin
			acquisition_irq <= acq_flag_q;
		end
	end

	// combine first, then swap, so a merged request follows the swap
	always @* begin
		req_one = motion_sample_request | acq_flag_q;
		req_two = fifo_request;
		if (request_combine_q) begin
			req_one = req_one | req_two;
			req_two = 1'b0;
		end
	end

	always @* begin
		if (request_swap_q) begin
			req_a = req_two;
			req_b = req_one;
		end else begin
			req_a = req_one;
			req_b = req_two;
		end
	end

	// pin settings are wired per physical pin, not per request
	wire pin_a_active_high = irq_pin_drive_polarity_q[`IRQR_BIT_A_AH];
	wire pin_a_push_pull = irq_pin_drive_polarity_q[`IRQR_BIT_A_PP];
	wire pin_b_active_high = irq_pin_drive_polarity_q[`IRQR_BIT_B_AH];
	wire pin_b_push_pull = irq_pin_drive_polarity_q[`IRQR_BIT_B_PP];

	irqr_pin_drv u_pin_a (
		.clk(clk),
		.sys_rst(sys_rst),
		.req(req_a),
		.active_high(pin_a_active_high),
		.push_pull(pin_a_push_pull),
		.pin_out_q(irq_pin_a_out),
		.pin_oe_q(irq_pin_a_oe)
	);

	irqr_pin_drv u_pin_b (
		.clk(clk),
		.sys_rst(sys_rst),
		.req(req_b),
		.active_high(pin_b_active_high),
		.push_pull(pin_b_push_pull),
		.pin_out_q(irq_pin_b_out),
		.pin_oe_q(irq_pin_b_oe)
	);
endmodule

// ---- logic/irqr_tick_div.v ----
/*
 * Event divider: emits one registered pulse for every PERIOD input
 * events. Assumes in_tick is synchronous to clk and period >= 1.
 */
module irqr_tick_div #(
	parameter W = 24
) (
	input wire clk,
	input wire sys_rst,
	input wire in_tick,
	input wire [W-1:0] period,
	output reg out_tick_q
);
	reg [W-1:0] cnt_q;
	reg [W-1:0] cnt_d;
	reg wrap;

	always @* begin
		wrap = (cnt_q + {{(W-1){1'b0}}, 1'b1}) >= period;
		cnt_d = cnt_q;
		if (in_tick) begin
			// >= keeps a shortened period from overrunning the count
			if (wrap) begin
				cnt_d = {W{1'b0}};
			end else begin
				cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= {W{1'b0}};
			out_tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_tick_q <= in_tick & wrap;
		end
	end
endmodule

// ---- testbench/irq_pin_routing_and_rate_decimation_tb_top.sv ----
/* bench for irqr_pin_rate: registers, pins, rates, samples.
   assumes CLK_HZ 4000 so that every rate period stays short */
module irq_pin_routing_and_rate_decimation_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	failures++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
	logic clk = 1'b0, sys_rst = 1'b1, we = 1'b0, re = 1'b0;
	logic en = 1'b0, clr = 1'b0, m = 1'b0, f = 1'b0;
	logic [7:0] ad = 8'h00, wd = 8'h00;
	logic [15:0] xi = 16'h0000;
	wire [7:0] rdq;
	wire [15:0] xo, yo, zo;
	wire it, ot, aq, ao, ae, bo, be, pa, pb;
	int failures = 0, checks_done = 0;
	irqr_pin_rate #(.CLK_HZ(4000)) i_irqr_pin_rate(.clk(clk),
		.sys_rst(sys_rst), .reg_addr(ad), .reg_wdata(wd), .reg_we(we),
		.reg_re(re), .reg_rdata_q(rdq), .acq_irq_en(en),
		.acq_irq_clear(clr), .motion_sample_request(m),
		.fifo_request(f), .x_sample_in(xi), .y_sample_in(xi),
		.z_sample_in(~xi), .x_sample_out(xo), .y_sample_out(yo),
		.z_sample_out(zo), .internal_rate_tick(it), .output_rate_tick(ot),
		.acquisition_irq(aq), .irq_pin_a_out(ao), .irq_pin_a_oe(ae),
		.irq_pin_b_out(bo), .irq_pin_b_oe(be));
	irqr_host i_irqr_host(.a_out(ao), .a_oe(ae), .b_out(bo), .b_oe(be),
		.pin_a(pa), .pin_b(pb));
	initial forever #50 clk = ~clk;
	task give_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		ad = a;
		wd = d;
		we = 1'b1;
		@(negedge clk);
		we = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		ad = a;
		re = 1'b1;
		@(negedge clk);
		re = 1'b0;
		`CHK("rdata", e, rdq)
	endtask
	// third gap only: the first after a change may be cut short
	task gap(input logic o, input int e);
		int n;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge clk);
				#1;
				n++;
			end while ((o ? ot : it) !== 1'b1 && n < 3000);
			if (n >= 3000) begin
				failures++;
				give_verdict;
			end
		end
		`CHK("tick gap", e, n)
	endtask
	task t_regs;
		logic [7:0] a [6] = '{8'h33, 8'h08, 8'h2D, 8'h31, 8'h30, 8'h40};
		logic [7:0] e [6] = '{8'hCC, 8'hFF, 8'h08, 8'h10, 8'h0F, 8'h00};
		rd(8'h33, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(a[i], 8'hFF);
			rd(a[i], e[i]);
		end
	endtask
	task t_pins;
		logic ra, rb;
		for (int i = 0; i < 256; i++) begin
			wr(8'h33, {i[3:2], 2'b00, i[1:0], 2'b00});
			wr(8'h31, {3'b000, i[4], 4'h0});
			wr(8'h2D, {4'h0, i[5], 3'b000});
			m = i[6];
			f = i[7];
			repeat (2) @(negedge clk);
			ra = i[4] ? i[7] & ~i[5] : i[6] | (i[5] & i[7]);
			rb = i[4] ? i[6] | (i[5] & i[7]) : i[7] & ~i[5];
			`CHK("oe a", i[1] | ra, ae)
			`CHK("pin a", ra ? i[0] : ~i[1] | ~i[0], pa)
			`CHK("oe b", i[3] | rb, be)
			`CHK("pin b", rb ? i[2] : ~i[3] | ~i[2], pb)
		end
	endtask
	task t_rate;
		int r [8] = '{50, 100, 125, 200, 250, 500, 1000, 2000};
		wr(8'h30, 8'h00);
		wr(8'h08, 8'h03);
		gap(1'b0, 4000 / 50);
		for (int i = 0; i < 8; i++) begin
			wr(8'h08, 8'(i + 8));
			gap(1'b0, 4000 / r[i]);
		end
	endtask
	task t_dec;
		int d [16] = '{1, 2, 4, 5, 8, 10, 16, 20, 40, 67, 80, 100, 200,
			250, 500, 1000};
		for (int i = 0; i < 16; i++) begin
			wr(8'h30, 8'(i));
			gap(1'b1, 2 * d[i]);
		end
		gap(1'b0, 2);
	endtask
	task t_samp;
		wr(8'h30, 8'h01);
		wr(8'h33, 8'h00);
		wr(8'h31, 8'h00);
		wr(8'h2D, 8'h00);
		m = 1'b0;
		f = 1'b0;
		en = 1'b1;
		xi = 16'hA5C3;
		gap(1'b1, 4);
		@(posedge clk);
		#1;
		`CHK("x out", 16'hA5C3, xo)
		`CHK("y out", 16'hA5C3, yo)
		`CHK("z out", 16'h5A3C, zo)
		@(posedge clk);
		#1;
		`CHK("acq", 1'b1, aq)
		`CHK("pin a", 1'b0, pa)
		@(negedge clk);
		en = 1'b0;
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		repeat (2) @(negedge clk);
		`CHK("pin a", 1'b1, pa)
	endtask
	initial begin
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		t_regs;
		t_pins;
		t_rate;
		t_dec;
		t_samp;
		give_verdict;
	end
endmodule

// ---- testbench/irqr_chk_asserts.sv ----
/* checker for irqr_pin_rate: pin routing, drive and rate timing.
   assumes only the top ports; shadows the routing registers */
module irqr_chk #(
	parameter SW = 16
) (
	input wire clk,
	input wire sys_rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_we,
	input wire acq_irq_en,
	input wire motion_sample_request,
	input wire fifo_request,
	input wire [SW-1:0] x_sample_in,
	input wire [SW-1:0] x_sample_out,
	input wire internal_rate_tick,
	input wire output_rate_tick,
	input wire acquisition_irq,
	input wire irq_pin_a_out,
	input wire irq_pin_a_oe,
	input wire irq_pin_b_out,
	input wire irq_pin_b_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rp, mp, fp, cq, sq, cp, sp;
	logic [7:0] pq, pp;
	wire r1, r2, ra, rb;
	// pins lag the request and the config by one edge, so compare
	// against one-edge-old copies; rp masks the first edge after reset
	always @(posedge clk) begin
		rp <= sys_rst;
		mp <= motion_sample_request;
		fp <= fifo_request;
		pp <= pq;
		cp <= cq;
		sp <= sq;
		if (sys_rst) begin
			pq <= 8'h00;
			cq <= 1'b0;
			sq <= 1'b0;
		end else if (reg_we) begin
			if (reg_addr == 8'h33) pq <= reg_wdata;
			if (reg_addr == 8'h2D) cq <= reg_wdata[3];
			if (reg_addr == 8'h31) sq <= reg_wdata[4];
		end
	end
	assign r1 = mp | acquisition_irq | (cp & fp);
	assign r2 = fp & ~cp;
	assign ra = sp ? r2 : r1;
	assign rb = sp ? r1 : r2;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst || rp);
	pin_a_pp_a: assert property (
		pp[3] |-> irq_pin_a_oe && irq_pin_a_out == (ra ~^ pp[2]))
		else $error("pin a push-pull wrong");
	pin_a_od_a: assert property (
		!pp[3] |-> irq_pin_a_oe == ra && irq_pin_a_out == pp[2])
		else $error("pin a open-drain wrong");
	pin_b_pp_a: assert property (
		pp[7] |-> irq_pin_b_oe && irq_pin_b_out == (rb ~^ pp[6]))
		else $error("pin b push-pull wrong");
	pin_b_od_a: assert property (
		!pp[7] |-> irq_pin_b_oe == rb && irq_pin_b_out == pp[6])
		else $error("pin b open-drain wrong");
	out_tick_a: assert property (
		output_rate_tick |-> $past(internal_rate_tick))
		else $error("output tick without rate tick");
	sample_load_a: assert property (
		output_rate_tick |=> x_sample_out == $past(x_sample_in))
		else $error("sample not loaded");
	sample_hold_a: assert property (
		!output_rate_tick |=> $stable(x_sample_out))
		else $error("sample changed between ticks");
	acq_raise_a: assert property (
		acq_irq_en && output_rate_tick |=> ##1 acquisition_irq)
		else $error("acquisition flag not raised");
endmodule

bind irqr_pin_rate irqr_chk #(.SW(SW)) i_irqr_chk(.clk(clk),
	.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_we(reg_we), .acq_irq_en(acq_irq_en),
	.motion_sample_request(motion_sample_request),
	.fifo_request(fifo_request), .x_sample_in(x_sample_in),
	.x_sample_out(x_sample_out), .internal_rate_tick(internal_rate_tick),
	.output_rate_tick(output_rate_tick), .acquisition_irq(acquisition_irq),
	.irq_pin_a_out(irq_pin_a_out), .irq_pin_a_oe(irq_pin_a_oe),
	.irq_pin_b_out(irq_pin_b_out), .irq_pin_b_oe(irq_pin_b_oe));

// ---- testbench/irqr_host.sv ----
/* host interrupt inputs with board pull-ups on both pins.
   assumes drive value and enable of each pin from the block */
module irqr_host (
	input wire a_out,
	input wire a_oe,
	input wire b_out,
	input wire b_oe,
	output wire pin_a,
	output wire pin_b
);
	timeunit 1ns;
	timeprecision 1ns;
	// a released pin floats to the pull-up, never to the last value
	assign pin_a = a_oe ? a_out : 1'b1;
	assign pin_b = b_oe ? b_out : 1'b1;
endmodule
